// ==== design/nlrc_config.sv ====
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// R01 - Detect-control bit 3 lets a card-detect event raise supply output b.
// R02 - Detect-control bit 4 lets a standby wake-up raise supply output a.
// R03 - Supply output rises, then lead count times 5 us passes before field on.
// R04 - After field off, lag count times 5 us passes before supply output clears.
// R05 - Sensitivity byte is presented to the field detector during field switch-on.
// R06 - Charge pumps settle count times 4 us before full transmitter drive.
// R07 - In card mode, external field is sampled every interval times 10 us.
// R08 - Request answer sends stored byte 0 then byte 1.
// R09 - Fixed identifier uses stored bytes 0, 1, 2 in that order.
// R10 - Identifier first byte is always 08h.
// R11 - Identifier check byte is the XOR of the identifier bytes.
// R12 - Polling answer: 01h, FEh, then sixteen stored bytes, eighteen in all.
// R13 - With random identifier on, a new one is taken at each field removal.
// R14 - Random select byte 0 keeps stored identifier, 1 uses random one.
// R15 - Detect-control bit 2 enables supply output a around field switching.
// R16 - Configuration bytes are held here and feed all engines directly.
// R17 - Select answer sends the single stored select byte.
module nlrc_config
    import nlrc_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // AXI4-Lite write
    input wire logic [11:0] axi_awaddr_in,
    input wire logic axi_awvalid_in,
    output logic axi_awready_out,
    input wire logic [31:0] axi_wdata_in,
    input wire logic [3:0] axi_wstrb_in,
    input wire logic axi_wvalid_in,
    output logic axi_wready_out,
    output logic [1:0] axi_bresp_out,
    output logic axi_bvalid_out,
    input wire logic axi_bready_in,
    // AXI4-Lite read
    input wire logic [11:0] axi_araddr_in,
    input wire logic axi_arvalid_in,
    output logic axi_arready_out,
    output logic [31:0] axi_rdata_out,
    output logic [1:0] axi_rresp_out,
    output logic axi_rvalid_out,
    input wire logic axi_rready_in,
    // Field control
    input wire logic field_req_in,
    input wire logic low_power_card_detect_in,
    input wire logic standby_wake_in,
    output nlrc_supply_t supply_out,
    output logic [7:0] external_field_detector_sens_out,
    // External field sensing
    input wire logic card_mode_in,
    input wire logic ext_field_pin_in,
    output logic ext_field_present_out,
    // Card emulation answers
    input wire nlrc_cmd_req_t cmd_in,
    output logic cmd_ready_out,
    output nlrc_resp_t resp_out,
    input wire logic resp_ready_in
);

    // ****************
    // Helpers
    // ****************
    function automatic logic [1:0] reg_kind(input logic [11:0] addr);
        logic [7:0] idx;
        idx = addr[9:2];
        if (addr[11:10] != ADDR_LSB_ZERO || addr[1:0] != ADDR_LSB_ZERO || idx < IDX_FIRST
            || idx > IDX_LAST) begin
            return KIND_UNMAPPED;
        end
        if (idx == IDX_RSVD_LO || idx == IDX_RSVD_HI) begin
            return KIND_RESERVED;
        end
        return KIND_RW;
    endfunction

    function automatic logic step_end(input logic [7:0] sub, input logic [7:0] len);
        return sub == len - 8'h01;
    endfunction

    // ****************
    // Configuration store
    // ****************
    logic [7:0] cfg [IDX_FIRST:IDX_LAST];
    logic aw_held;
    logic [11:0] aw_addr;
    logic w_held;
    logic [7:0] w_byte;
    logic w_lane0;
    logic [1:0] bresp;
    logic bvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;

    wire logic do_write = aw_held && w_held && !bvalid;
    wire logic [1:0] wr_kind = reg_kind(aw_addr);
    wire logic [7:0] wr_idx = aw_addr[9:2];
    wire logic [1:0] rd_kind = reg_kind(axi_araddr_in);
    wire logic [7:0] rd_idx = axi_araddr_in[9:2];
    wire logic [7:0] rd_byte = (rd_kind == KIND_RW) ? cfg[rd_idx] : RESET_BYTE;
    wire logic take_ar = axi_arvalid_in && !rvalid;

    assign axi_awready_out = !aw_held;
    assign axi_wready_out = !w_held;
    assign axi_bresp_out = bresp;
    assign axi_bvalid_out = bvalid;
    assign axi_arready_out = !rvalid;
    assign axi_rdata_out = rdata;
    assign axi_rresp_out = rresp;
    assign axi_rvalid_out = rvalid;

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_byte <= RESET_BYTE;
            w_lane0 <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else begin
            if (axi_awvalid_in && !aw_held) begin
                aw_held <= 1'b1;
                aw_addr <= axi_awaddr_in;
            end
            if (axi_wvalid_in && !w_held) begin
                w_held <= 1'b1;
                w_byte <= axi_wdata_in[7:0];
                w_lane0 <= axi_wstrb_in[0];
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                bvalid <= 1'b1;
                bresp <= (wr_kind == KIND_UNMAPPED) ? RESP_SLVERR : RESP_OKAY;
            end else if (bvalid && axi_bready_in) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Bytes live in flops so every engine sees a stored value at once.
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            for (int i = IDX_FIRST; i <= IDX_LAST; i++) begin
                cfg[i] <= RESET_BYTE;
            end
        end else if (do_write && w_lane0 && wr_kind == KIND_RW) begin
            cfg[wr_idx] <= w_byte; // R16
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end else if (take_ar) begin
            rvalid <= 1'b1;
            rdata <= {24'h00_0000, rd_byte};
            rresp <= (rd_kind == KIND_UNMAPPED) ? RESP_SLVERR : RESP_OKAY;
        end else if (rvalid && axi_rready_in) begin
            rvalid <= 1'b0;
        end
    end

    // ****************
    // Supply and field sequencer
    // ****************
    typedef enum logic [2:0] {SQ_IDLE, SQ_LEAD, SQ_SETTLE, SQ_ON, SQ_LAG} nlrc_seq_t;
    nlrc_seq_t seq;
    logic [7:0] seq_steps;
    logic [7:0] seq_sub;
    logic hold_a;
    logic hold_b;
    logic [7:0] sens;

    wire logic [7:0] detect_ctrl = cfg[IDX_DETECT_CTRL];
    wire logic en_a = detect_ctrl[BIT_SUPPLY_A_EN];
    wire logic [7:0] seq_len = (seq == SQ_SETTLE) ? SETTLE_STEP_CYC : SUPPLY_STEP_CYC;
    wire logic seq_done = (seq_steps == 8'h00);
    wire logic seq_tick = !seq_done && step_end(seq_sub, seq_len);
    wire logic seq_last = seq_done || (seq_tick && seq_steps == 8'h01);

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            seq <= SQ_IDLE;
            seq_steps <= 8'h00;
            seq_sub <= 8'h00;
        end else begin
            seq_sub <= (seq_done || seq_tick) ? 8'h00 : seq_sub + 8'h01;
            if (seq_tick) begin
                seq_steps <= seq_steps - 8'h01;
            end
            unique case (seq)
                SQ_IDLE: begin
                    if (field_req_in && (en_a || hold_a || hold_b)) begin
                        seq <= SQ_LEAD;
                        seq_steps <= cfg[IDX_SUPPLY_LEAD]; // R03
                    end else if (field_req_in) begin
                        seq <= SQ_SETTLE;
                        seq_steps <= cfg[IDX_CP_SETTLE];
                    end
                end
                SQ_LEAD: begin
                    if (seq_last) begin
                        seq <= SQ_SETTLE;
                        seq_steps <= cfg[IDX_CP_SETTLE]; // R06
                    end
                end
                SQ_SETTLE: begin
                    if (seq_last) begin
                        seq <= SQ_ON;
                    end
                end
                SQ_ON: begin
                    if (!field_req_in) begin
                        seq <= SQ_LAG;
                        seq_steps <= cfg[IDX_SUPPLY_LAG]; // R04
                    end
                end
                SQ_LAG: begin
                    if (seq_last) begin
                        seq <= SQ_IDLE;
                    end
                end
            endcase
        end
    end

    // The wake-up and card-detect holds last until a lag completes.
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            hold_a <= 1'b0;
            hold_b <= 1'b0;
            sens <= RESET_BYTE;
        end else begin
            if (standby_wake_in && detect_ctrl[BIT_WAKE_A_EN]) begin
                hold_a <= 1'b1; // R02
            end else if (seq == SQ_LAG && seq_last) begin
                hold_a <= 1'b0;
            end
            if (low_power_card_detect_in && detect_ctrl[BIT_DETECT_B_EN]) begin
                hold_b <= 1'b1; // R01
            end else if (seq == SQ_LAG && seq_last) begin
                hold_b <= 1'b0;
            end
            if (seq == SQ_LEAD || (seq == SQ_IDLE && field_req_in)) begin
                sens <= cfg[IDX_SENSITIVITY]; // R05
            end
        end
    end

    wire logic seq_active = (seq != SQ_IDLE);
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            supply_out <= '0;
        end else begin
            supply_out.ctrl_a <= hold_a || (en_a && seq_active); // R15
            supply_out.ctrl_b <= hold_b;
            supply_out.field_on <= (seq == SQ_SETTLE) || (seq == SQ_ON);
            supply_out.full_drive <= (seq == SQ_ON); // R06
        end
    end
    assign external_field_detector_sens_out = sens;

    // ****************
    // External field sampling and random identifier
    // ****************
    logic field_meta;
    logic field_sync;
    logic present;
    logic [7:0] db_steps;
    logic [7:0] db_sub;
    logic [23:0] lfsr;
    logic [23:0] rand_uid;

    wire logic db_done = (db_steps == 8'h00);
    wire logic db_tick = !db_done && step_end(db_sub, DEBOUNCE_STEP_CYC);
    wire logic next_present = card_mode_in ? (db_done ? field_sync : present) : field_sync;
    wire logic removal = present && !next_present;
    wire logic random_on = (cfg[IDX_RANDOM_UID] == RANDOM_UID_ON);

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            field_meta <= 1'b0;
            field_sync <= 1'b0;
            present <= 1'b0;
            db_steps <= 8'h00;
            db_sub <= 8'h00;
        end else begin
            field_meta <= ext_field_pin_in;
            field_sync <= field_meta;
            present <= next_present;
            db_sub <= (db_done || db_tick) ? 8'h00 : db_sub + 8'h01;
            if (db_done) begin
                db_steps <= cfg[IDX_DEBOUNCE]; // R07
            end else if (db_tick) begin
                db_steps <= db_steps - 8'h01;
            end
        end
    end
    assign ext_field_present_out = present;

    // A free-running generator keeps the value unpredictable between removals.
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            lfsr <= LFSR_SEED;
            rand_uid <= 24'h00_0000;
        end else begin
            lfsr <= lfsr[0] ? ((lfsr >> 1) ^ LFSR_TAPS) : (lfsr >> 1);
            if (removal && random_on) begin
                rand_uid <= lfsr; // R13
            end
        end
    end

    // ****************
    // Card emulation answers
    // ****************
    typedef enum logic {RS_IDLE, RS_SEND} nlrc_rs_t;
    nlrc_rs_t rs;
    nlrc_cmd_t rs_kind;
    logic [4:0] rs_idx;
    logic [4:0] rs_len;
    logic [7:0] rs_data;

    wire logic [23:0] uid_bytes = random_on ? rand_uid // R14
        : {cfg[IDX_FIXED_UID], cfg[IDX_FIXED_UID + 8'h01], cfg[IDX_FIXED_UID + 8'h02]}; // R09
    wire logic [7:0] uid_check = UID_FIRST_BYTE ^ uid_bytes[23:16] ^ uid_bytes[15:8]
        ^ uid_bytes[7:0]; // R11
    wire logic cmd_take = cmd_in.valid && (rs == RS_IDLE);
    wire logic byte_take = (rs == RS_SEND) && resp_ready_in;
    wire nlrc_cmd_t sel_kind = (rs == RS_IDLE) ? cmd_in.kind : rs_kind;
    wire logic [4:0] sel_idx = (rs == RS_IDLE) ? 5'h00 : rs_idx + 5'h01;
    wire logic [7:0] sel_off = {3'h0, sel_idx};
    logic [7:0] sel_byte;
    logic [4:0] sel_len;

    always_comb begin
        sel_byte = RESET_BYTE;
        sel_len = LEN_REQ;
        unique case (sel_kind)
            CMD_REQ: begin
                sel_byte = cfg[IDX_REQ_ANSWER + sel_off[0]]; // R08
            end
            CMD_SELECT: begin
                sel_len = LEN_SELECT;
                sel_byte = cfg[IDX_SELECT_ANSWER]; // R17
            end
            CMD_POLL: begin
                sel_len = LEN_POLL;
                if (sel_idx == 5'h00) begin
                    sel_byte = POLL_HEADER_0; // R12
                end else if (sel_idx == 5'h01) begin
                    sel_byte = POLL_HEADER_1; // R12
                end else if (sel_idx < LEN_POLL) begin
                    sel_byte = cfg[IDX_POLL_ANSWER + sel_off];
                end
            end
            CMD_UID: begin
                sel_len = LEN_UID;
                unique case (sel_idx)
                    5'h00: sel_byte = UID_FIRST_BYTE; // R10
                    5'h01: sel_byte = uid_bytes[23:16];
                    5'h02: sel_byte = uid_bytes[15:8];
                    5'h03: sel_byte = uid_bytes[7:0];
                    default: sel_byte = uid_check;
                endcase
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            rs <= RS_IDLE;
            rs_kind <= CMD_REQ;
            rs_idx <= 5'h00;
            rs_len <= LEN_REQ;
            rs_data <= RESET_BYTE;
        end else if (cmd_take) begin
            rs <= RS_SEND;
            rs_kind <= cmd_in.kind;
            rs_idx <= 5'h00;
            rs_len <= sel_len;
            rs_data <= sel_byte;
        end else if (byte_take) begin
            if (rs_idx == rs_len - 5'h01) begin
                rs <= RS_IDLE;
            end else begin
                rs_idx <= sel_idx;
                rs_data <= sel_byte;
            end
        end
    end

    assign cmd_ready_out = (rs == RS_IDLE);
    assign resp_out.valid = (rs == RS_SEND);
    assign resp_out.last = (rs == RS_SEND) && (rs_idx == rs_len - 5'h01);
    assign resp_out.data = rs_data;

endmodule // nlrc_config
`default_nettype wire

// ==== shared/nlrc_pkg.sv ====
`default_nettype none
package nlrc_pkg;
    // ****************
    // Timing
    // ****************
    localparam int CLK_PERIOD_NS = 40;
    localparam int SUPPLY_STEP_NS = 5000;
    localparam int SETTLE_STEP_NS = 4000;
    localparam int DEBOUNCE_STEP_NS = 10000;
    localparam logic [7:0] SUPPLY_STEP_CYC = 8'(SUPPLY_STEP_NS / CLK_PERIOD_NS);
    localparam logic [7:0] SETTLE_STEP_CYC = 8'(SETTLE_STEP_NS / CLK_PERIOD_NS);
    localparam logic [7:0] DEBOUNCE_STEP_CYC = 8'(DEBOUNCE_STEP_NS / CLK_PERIOD_NS);

    // ****************
    // Register indices, byte address is four times the index
    // ****************
    localparam logic [7:0] IDX_FIRST = 8'h38;
    localparam logic [7:0] IDX_DETECT_CTRL = 8'h38;
    localparam logic [7:0] IDX_SUPPLY_LEAD = 8'h39;
    localparam logic [7:0] IDX_SUPPLY_LAG = 8'h3a;
    localparam logic [7:0] IDX_SENSITIVITY = 8'h3b;
    localparam logic [7:0] IDX_CP_SETTLE = 8'h3c;
    localparam logic [7:0] IDX_RSVD_LO = 8'h3d;
    localparam logic [7:0] IDX_RSVD_HI = 8'h3e;
    localparam logic [7:0] IDX_DEBOUNCE = 8'h3f;
    localparam logic [7:0] IDX_REQ_ANSWER = 8'h40;
    localparam logic [7:0] IDX_FIXED_UID = 8'h42;
    localparam logic [7:0] IDX_SELECT_ANSWER = 8'h45;
    localparam logic [7:0] IDX_POLL_ANSWER = 8'h46;
    localparam logic [7:0] IDX_RANDOM_UID = 8'h51;
    localparam logic [7:0] IDX_LAST = 8'h57;
    localparam logic [1:0] ADDR_LSB_ZERO = 2'h0;

    // ****************
    // Fields and fixed values
    // ****************
    localparam int BIT_SUPPLY_A_EN = 2;
    localparam int BIT_DETECT_B_EN = 3;
    localparam int BIT_WAKE_A_EN = 4;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] RANDOM_UID_ON = 8'h01;
    localparam logic [7:0] UID_FIRST_BYTE = 8'h08;
    localparam logic [7:0] POLL_HEADER_0 = 8'h01;
    localparam logic [7:0] POLL_HEADER_1 = 8'hfe;
    localparam logic [23:0] LFSR_SEED = 24'h00_0001;
    localparam logic [23:0] LFSR_TAPS = 24'he1_0000;
    localparam logic [4:0] LEN_REQ = 5'h02;
    localparam logic [4:0] LEN_SELECT = 5'h01;
    localparam logic [4:0] LEN_POLL = 5'h12;
    localparam logic [4:0] LEN_UID = 5'h05;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] KIND_UNMAPPED = 2'h0;
    localparam logic [1:0] KIND_RESERVED = 2'h1;
    localparam logic [1:0] KIND_RW = 2'h2;

    // ****************
    // Types
    // ****************
    typedef enum logic [1:0] {CMD_REQ, CMD_SELECT, CMD_POLL, CMD_UID} nlrc_cmd_t;
    typedef struct packed {
        logic valid;
        nlrc_cmd_t kind;
    } nlrc_cmd_req_t;
    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } nlrc_resp_t;
    typedef struct packed {
        logic ctrl_a;
        logic ctrl_b;
        logic field_on;
        logic full_drive;
    } nlrc_supply_t;
endpackage
`default_nettype wire

// ==== verif/nlrc_config_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module nlrc_config_monitor
    import nlrc_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Register bus
    input wire logic axi_awvalid_in,
    input wire logic axi_awready_out,
    input wire logic axi_wvalid_in,
    input wire logic axi_wready_out,
    input wire logic [1:0] axi_bresp_out,
    input wire logic axi_bvalid_out,
    input wire logic axi_bready_in,
    input wire logic axi_arvalid_in,
    input wire logic axi_arready_out,
    input wire logic axi_rvalid_out,
    // Field and answers
    input wire nlrc_supply_t supply_out,
    input wire nlrc_cmd_req_t cmd_in,
    input wire logic cmd_ready_out,
    input wire nlrc_resp_t resp_out,
    input wire logic resp_ready_in
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    wire take = cmd_in.valid && cmd_ready_out;

    AST_READ_ANSWER:
        assert property (axi_arvalid_in && axi_arready_out |=> axi_rvalid_out)
        else $error("read not answered");
    AST_WRITE_ANSWER:
        assert property (axi_awvalid_in && axi_awready_out && axi_wvalid_in && axi_wready_out
            |-> ##[1:2] axi_bvalid_out) else $error("write not answered");
    AST_BRESP_STANDS:
        assert property (axi_bvalid_out && !axi_bready_in |=> axi_bvalid_out
            && $stable(axi_bresp_out)) else $error("write response dropped");
    AST_DRIVE_AFTER_FIELD:
        assert property (supply_out.full_drive |-> supply_out.field_on)
        else $error("full drive without field");
    AST_SUPPLY_AFTER_OFF:
        assert property ($fell(supply_out.ctrl_a) |-> !supply_out.field_on)
        else $error("supply cleared with field on");
    AST_POLL_HEADER:
        assert property (take && cmd_in.kind == CMD_POLL |=> resp_out.valid
            && resp_out.data == POLL_HEADER_0 && !resp_out.last) else $error("poll header");
    AST_UID_FIRST:
        assert property (take && cmd_in.kind == CMD_UID |=> resp_out.valid
            && resp_out.data == UID_FIRST_BYTE) else $error("uid first byte");
    AST_SELECT_SINGLE:
        assert property (take && cmd_in.kind == CMD_SELECT |=> resp_out.valid && resp_out.last)
        else $error("select answer length");
    AST_REQ_TWO:
        assert property (take && cmd_in.kind == CMD_REQ |=> resp_out.valid && !resp_out.last)
        else $error("request answer length");
    AST_BYTE_HOLDS:
        assert property (resp_out.valid && !resp_ready_in |=> resp_out.valid
            && $stable(resp_out.data)) else $error("answer byte not held");
endmodule // nlrc_config_monitor
bind nlrc_config nlrc_config_monitor u_mon (.*);
`default_nettype wire

// ==== verif/nlrc_reader_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module nlrc_reader_model
    import nlrc_pkg::*;
(
    // Clock and bench control
    input wire logic clk_in,
    input wire logic field_in,
    input wire logic slow_in,
    // Block side
    input wire nlrc_resp_t resp_in,
    output logic resp_ready_out,
    output logic ext_field_pin_out
);
    logic [7:0] got [$];
    logic tick = 1'b0;
    // A slow reader stalls every other cycle so held bytes get exercised.
    assign resp_ready_out = !slow_in || tick;
    assign ext_field_pin_out = field_in;
    always @(posedge clk_in) begin
        tick <= !tick;
        if (resp_in.valid === 1'b1 && resp_ready_out) begin
            got.push_back(resp_in.data);
        end
    end
endmodule // nlrc_reader_model
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb import nlrc_pkg::*;;
    logic clk_in = 1'b0, resetn_in = 1'b0, fld = 1'b0, slow = 1'b0;
    logic [11:0] axi_awaddr_in = '0, axi_araddr_in = '0;
    logic [31:0] axi_wdata_in = '0, axi_rdata_out;
    logic [3:0] axi_wstrb_in = 4'hf;
    logic axi_awvalid_in = 1'b0, axi_wvalid_in = 1'b0, axi_bready_in = 1'b0;
    logic axi_arvalid_in = 1'b0, axi_rready_in = 1'b0, axi_awready_out, axi_wready_out;
    logic axi_bvalid_out, axi_arready_out, axi_rvalid_out, cmd_ready_out, resp_ready_in;
    logic [1:0] axi_bresp_out, axi_rresp_out;
    logic field_req_in = 1'b0, low_power_card_detect_in = 1'b0, standby_wake_in = 1'b0;
    logic card_mode_in = 1'b0, ext_field_pin_in, ext_field_present_out;
    logic [7:0] external_field_detector_sens_out;
    nlrc_supply_t supply_out;
    nlrc_cmd_req_t cmd_in = '0;
    nlrc_resp_t resp_out;
    logic [7:0] eq [$];
    int mismatches = 0, tests_run = 0;
    nlrc_config dut (.*);
    nlrc_reader_model u_rd (.clk_in, .field_in(fld), .slow_in(slow), .resp_in(resp_out),
        .resp_ready_out(resp_ready_in), .ext_field_pin_out(ext_field_pin_in));
    always #20 clk_in = !clk_in;
    // ****************
    // Helpers
    // ****************
    task automatic print_verdict();
        if (mismatches == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tmo();
        chk(32'h0, 32'h1);
        print_verdict();
    endtask
    task automatic wr(input logic [9:0] i, input logic [7:0] d, input logic [1:0] e = RESP_OKAY);
        int n;
        axi_awaddr_in <= {i, 2'b00};
        axi_wdata_in <= {24'h00_0000, d};
        axi_awvalid_in <= 1'b1;
        axi_wvalid_in <= 1'b1;
        axi_bready_in <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_in);
            if (axi_awready_out) axi_awvalid_in <= 1'b0;
            if (axi_wready_out) axi_wvalid_in <= 1'b0;
            if (axi_bvalid_out) break;
        end
        if (n == 50) tmo();
        chk(32'(axi_bresp_out), 32'(e));
        axi_bready_in <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic rd(input logic [9:0] i, input logic [7:0] d, input logic [1:0] e = RESP_OKAY);
        int n;
        axi_araddr_in <= {i, 2'b00};
        axi_arvalid_in <= 1'b1;
        axi_rready_in <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_in);
            if (axi_arready_out) axi_arvalid_in <= 1'b0;
            if (axi_rvalid_out) break;
        end
        if (n == 50) tmo();
        chk(axi_rdata_out, {24'h00_0000, d});
        chk(32'(axi_rresp_out), 32'(e));
        axi_rready_in <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic ask(input nlrc_cmd_t k, input logic c);
        int n;
        u_rd.got.delete();
        cmd_in <= '{1'b1, k};
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (cmd_ready_out !== 1'b1 && n < 50);
        if (cmd_ready_out !== 1'b1) tmo();
        cmd_in <= '{1'b0, k};
        for (n = 0; n < 200 && u_rd.got.size() < eq.size(); n++) @(posedge clk_in);
        if (n == 200) tmo();
        repeat (3) @(posedge clk_in);
        if (c) begin
            chk(32'(u_rd.got.size()), 32'(eq.size()));
            for (n = 0; n < eq.size(); n++) chk(32'(u_rd.got[n]), 32'(eq[n]));
        end
    endtask
    task automatic wait_sup(input int b, input logic v, output int n);
        for (n = 0; n < 2000 && supply_out[b] !== v; n++) @(posedge clk_in);
        if (n == 2000) tmo();
    endtask
    task automatic pulse();
        {low_power_card_detect_in, standby_wake_in} <= 2'b11;
        @(posedge clk_in);
        {low_power_card_detect_in, standby_wake_in} <= 2'b00;
        repeat (3) @(posedge clk_in);
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_regs();
        rd(IDX_SELECT_ANSWER, RESET_BYTE);
        wr(IDX_SELECT_ANSWER, 8'h3c);
        rd(IDX_SELECT_ANSWER, 8'h3c);
        wr(IDX_RSVD_LO, 8'ha5);
        rd(IDX_RSVD_LO, 8'h00);
        wr(10'h145, 8'h11, RESP_SLVERR);
        rd(10'h145, 8'h00, RESP_SLVERR);
    endtask
    task automatic t_answers();
        int i;
        wr(IDX_REQ_ANSWER, 8'ha5);
        wr(IDX_REQ_ANSWER + 8'h01, 8'h5a);
        eq = '{8'ha5, 8'h5a};
        ask(CMD_REQ, 1'b1);
        eq = '{8'h3c};
        ask(CMD_SELECT, 1'b1);
        eq = '{POLL_HEADER_0, POLL_HEADER_1};
        for (i = 8'h46; i < 8'h58; i++) begin
            wr(10'(i), 8'(i) ^ 8'h80);
            if (i > 8'h47) eq.push_back(8'(i) ^ 8'h80);
        end
        slow <= 1'b1;
        ask(CMD_POLL, 1'b1);
        slow <= 1'b0;
    endtask
    task automatic t_random();
        int n;
        for (n = 0; n < 3; n++) wr(IDX_FIXED_UID + 8'(n), 8'(8'h11 * (n + 1)));
        eq = '{UID_FIRST_BYTE, 8'h11, 8'h22, 8'h33, UID_FIRST_BYTE ^ 8'h11 ^ 8'h22 ^ 8'h33};
        ask(CMD_UID, 1'b1);
        wr(IDX_DEBOUNCE, 8'h01);
        wr(IDX_RANDOM_UID, RANDOM_UID_ON);
        card_mode_in <= 1'b1;
        fld <= 1'b1;
        for (n = 0; n < 400 && ext_field_present_out !== 1'b1; n++) @(posedge clk_in);
        chk(32'(n < 260), 32'h1);
        fld <= 1'b0;
        for (n = 0; n < 400 && ext_field_present_out !== 1'b0; n++) @(posedge clk_in);
        if (n == 400) tmo();
        ask(CMD_UID, 1'b0);
        chk(32'({u_rd.got[1], u_rd.got[2], u_rd.got[3]} != 24'h11_2233), 32'h1);
        chk(32'(u_rd.got[4]), 32'(u_rd.got[0] ^ u_rd.got[1] ^ u_rd.got[2] ^ u_rd.got[3]));
        wr(IDX_RANDOM_UID, 8'h00);
        ask(CMD_UID, 1'b1);
        card_mode_in <= 1'b0;
    endtask
    task automatic t_supply();
        int n;
        wr(IDX_SUPPLY_LEAD, 8'h01);
        wr(IDX_CP_SETTLE, 8'h02);
        wr(IDX_SUPPLY_LAG, 8'h01);
        wr(IDX_SENSITIVITY, 8'h5c);
        wr(IDX_DETECT_CTRL, 8'h00);
        pulse();
        chk(32'(supply_out[3:2]), 32'h0);
        wr(IDX_DETECT_CTRL, 8'h18);
        pulse();
        chk(32'(supply_out[3:2]), 32'h3);
        field_req_in <= 1'b1;
        wait_sup(0, 1'b1, n);
        chk(32'(external_field_detector_sens_out), 32'h5c);
        field_req_in <= 1'b0;
        wait_sup(3, 1'b0, n);
        repeat (2) @(posedge clk_in);
        chk(32'(supply_out[3:2]), 32'h0);
        wr(IDX_DETECT_CTRL, 8'h04);
        field_req_in <= 1'b1;
        wait_sup(3, 1'b1, n);
        wait_sup(1, 1'b1, n);
        chk(32'(n), 32'(SUPPLY_STEP_CYC));
        wait_sup(0, 1'b1, n);
        chk(32'(n), 32'(SETTLE_STEP_CYC) * 2);
        field_req_in <= 1'b0;
        wait_sup(0, 1'b0, n);
        wait_sup(3, 1'b0, n);
        chk(32'(n), 32'(SUPPLY_STEP_CYC));
        wr(IDX_DETECT_CTRL, 8'h00);
        field_req_in <= 1'b1;
        wait_sup(0, 1'b1, n);
        chk(32'(supply_out.ctrl_a), 32'h0);
        field_req_in <= 1'b0;
        wait_sup(1, 1'b0, n);
    endtask
    initial begin
        repeat (16) @(posedge clk_in);
        resetn_in <= 1'b1;
        @(posedge clk_in);
        t_regs();
        t_answers();
        t_random();
        t_supply();
        print_verdict();
    end
endmodule // tb
`default_nettype wire
